// >>> flash_array_model.sv
// Behavioural flash array answering each start pulse with a done pulse.
// Assumes one operation at a time, started by the block on pclk.
`timescale 1ns/1ps
`default_nettype none

module flash_array_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic slow,
   input  wire logic nvm_start,
   output logic      nvm_done
);
   int unsigned left_q;

   // Count down the busy time, then pulse done for one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left_q   <= 0;
         nvm_done <= 1'b0;
      end else begin
         nvm_done <= (left_q == 1);
         if (nvm_start) begin
            left_q <= slow ? 12 : 1; // Prompt or slow array
         end else if (left_q != 0) begin
            left_q <= left_q - 1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> flash_lock_defines.svh
// Constants for the flash lock, security and remap block.
// Assumes inclusion by the design file only.
`ifndef FLASH_LOCK_DEFINES_SVH
`define FLASH_LOCK_DEFINES_SVH

// Register byte offsets on the APB
`define OFS_MODE        12'h000
`define OFS_CMD         12'h004
`define OFS_STATUS      12'h008
`define OFS_REMAP       12'h00C

// Mode register fields
`define MODE_LOCK_IE    0
`define MODE_PROG_IE    1
`define MODE_WS_LSB     8
`define MODE_RESET      32'h0000_0000

// Command register fields
`define CMD_CODE_LSB    0
`define CMD_PAGE_LSB    8
`define CMD_KEY_LSB     24

// Command codes
`define CMD_WRITE_PAGE  8'h01
`define CMD_SET_LOCK    8'h02
`define CMD_CLR_LOCK    8'h04
`define CMD_ERASE_ALL   8'h08
`define CMD_SET_GPNV    8'h0B
`define CMD_CLR_GPNV    8'h0D
`define CMD_SET_SEC     8'h0F

// Status register fields
`define ST_READY        0
`define ST_LOCK_ERR     2
`define ST_PROG_ERR     3
`define ST_SECURITY     4
`define ST_GPNV_LSB     8
`define ST_LOCK_LSB     16

// Memory map
`define SRAM_BASE       32'h0020_0000
`define FLASH_BASE      32'h0010_0000
`define ZERO_BASE       32'h0000_0000
`define AREA_MASK       32'hFFF0_0000

// Timing
`define CLK_PERIOD_NS   8
`define ERASE_HOLD_MS   50
`define ERASE_HOLD_CYC  ((`ERASE_HOLD_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// >>> flash_lock_pkg.sv
// Types for the flash lock, security and remap block.
// Assumes the constants header sits in the same folder.
package flash_lock_pkg;
   typedef enum logic [1:0] {
      CTRL_IDLE,
      CTRL_BUSY,
      CTRL_PIN_ERASE
   } ctrl_state_type;
   typedef logic [7:0] lock_vec_type;
   typedef logic [1:0] gpnv_vec_type;
   typedef logic [1:0] wait_type;
endpackage

// >>> flash_lock_security_remap.sv
// Remap decoder, lock, security and general bits of the flash controller.
// Assumes an APB master on pclk, a flash array that runs one operation
// per start pulse and answers with a done pulse, and an image of the
// non-volatile bits that is valid at reset release.
//
// Notes on behaviour
// - Before remap, SRAM decodes only at its fixed base.
// - After remap, SRAM also decodes at address zero.
// - Flash always decodes at its fixed base.
// - Before remap, flash also decodes at address zero.
// - Boot ROM is never selected after reset.
// - Eight lock bits, each guarding 32 pages of 64 bytes.
// - Erase or program on a locked region aborts and sets lock error.
// - Lock error raises the interrupt only when its enable is one.
// - Set-lock sets the region bit, clear-lock clears it.
// - Erase pin clears every lock bit.
// - Security bit set refuses emulation and fast programming access.
// - Only the set-security command sets security; nothing soft clears it.
// - Security clears after erase pin and a completed full erase.
// - Two general bits, set and cleared by commands, kept non-volatile.
// - General bit 0 drives the brownout detector enable.
// - Erase pin clears general bit 0.
// - General bit 1 drives the brownout reset enable.
// - Erase pin clears general bit 1.
// - Flash reads take zero to three programmable wait states.
// - Program, erase and lock commands need the correct key.
// - A forbidden operation raises the interrupt when its enable bit is one.
`include "flash_lock_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_lock_security_remap #(
   parameter logic [7:0]  CMD_KEY           = 8'hA5, // Arbitrary key
   parameter int unsigned ERASE_HOLD_CYCLES = `ERASE_HOLD_CYC
) (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic [31:0]             cpu_addr,
   output logic                         sel_sram,
   output logic                         sel_flash,
   output logic                         sel_rom,
   input  wire logic                    fr_req,
   output logic                         fr_ready,
   input  wire logic                    ice_flash_req,
   output logic                         ice_flash_grant,
   input  wire logic                    fast_flash_program_port_flash_req,
   output logic                         fast_flash_program_port_flash_grant,
   input  wire logic                    erase_pin,
   input  wire flash_lock_pkg::lock_vec_type nv_lock_image,
   input  wire flash_lock_pkg::gpnv_vec_type nv_gpnv_image,
   input  wire logic                    nv_sec_image,
   output logic                         nvm_start,
   output logic      [7:0]              nvm_op,
   output logic      [7:0]              nvm_page,
   input  wire logic                    nvm_done,
   output flash_lock_pkg::lock_vec_type lock_bits,
   output logic                         security,
   output logic                         bod_enable,
   output logic                         bod_reset_enable,
   output logic                         flash_irq
);
   import flash_lock_pkg::*;

   // Registers
   ctrl_state_type state_q;
   ctrl_state_type state_d;
   lock_vec_type   lock_q;
   gpnv_vec_type   gpnv_q;
   logic           sec_q;
   logic           remap_q;
   logic           load_q;
   logic [31:0]    mode_q;
   logic           lock_err_q;
   logic           prog_err_q;
   logic           erase_armed_q;
   logic           erase_s1_q;
   logic           erase_s2_q;
   logic [31:0]    hold_cnt_q;
   logic [7:0]     op_q;
   logic [7:0]     page_q;
   logic           start_q;
   logic [31:0]    prdata_q;
   logic [1:0]     ws_cnt_q;

   // APB decode
   wire setup_ph  = psel & ~penable;
   wire access_ph = psel & penable;
   wire hit_mode  = paddr == `OFS_MODE;
   wire hit_cmd   = paddr == `OFS_CMD;
   wire hit_stat  = paddr == `OFS_STATUS;
   wire hit_remap = paddr == `OFS_REMAP;
   wire mapped    = hit_mode | hit_cmd | hit_stat | hit_remap;
   wire wr_en     = access_ph & pwrite & mapped;
   wire rd_stat   = access_ph & ~pwrite & hit_stat;
   wire cmd_wr    = wr_en & hit_cmd;

   // Command fields and checks
   wire [7:0] code     = pwdata[`CMD_CODE_LSB +: 8];
   wire [7:0] page     = pwdata[`CMD_PAGE_LSB +: 8];
   wire       key_ok   = pwdata[`CMD_KEY_LSB +: 8] == CMD_KEY;
   wire       is_write = code == `CMD_WRITE_PAGE;
   wire       is_erase = code == `CMD_ERASE_ALL;
   wire       known    = is_write | is_erase | (code == `CMD_SET_LOCK) |
                         (code == `CMD_CLR_LOCK) | (code == `CMD_SET_GPNV) |
                         (code == `CMD_CLR_GPNV) | (code == `CMD_SET_SEC);
   // Region of a page is its top three bits: 32 pages per region
   wire [2:0] region   = page[7:5];
   wire       hits_lock = (is_write & lock_q[region]) |
                          (is_erase & (|lock_q));
   wire       idle      = state_q == CTRL_IDLE;
   wire       cmd_bad   = cmd_wr & (~key_ok | ~known | ~idle);
   wire       cmd_lock  = cmd_wr & ~cmd_bad & hits_lock;
   wire       cmd_go    = cmd_wr & ~cmd_bad & ~hits_lock;
   wire       pin_high  = erase_s2_q;
   wire       held_long = hold_cnt_q >= ERASE_HOLD_CYCLES;
   wire       pin_go    = idle & erase_armed_q & held_long & ~cmd_go;

   // Address decode of the three internal areas
   wire [31:0] area     = cpu_addr & `AREA_MASK;
   wire        at_zero  = area == `ZERO_BASE;
   assign sel_sram  = (area == `SRAM_BASE) | (at_zero & remap_q);
   assign sel_flash = (area == `FLASH_BASE) | (at_zero & ~remap_q);
   assign sel_rom   = 1'b0;

   // Debug and fast programming access gate
   assign ice_flash_grant  = ice_flash_req & ~sec_q;
   assign fast_flash_program_port_flash_grant = fast_flash_program_port_flash_req & ~sec_q;

   // Outputs from state
   assign lock_bits        = lock_q;
   assign security         = sec_q;
   assign bod_enable       = gpnv_q[0];
   assign bod_reset_enable = gpnv_q[1];
   assign nvm_start        = start_q;
   assign nvm_op           = op_q;
   assign nvm_page         = page_q;
   assign flash_irq = (lock_err_q & mode_q[`MODE_LOCK_IE]) |
                      (prog_err_q & mode_q[`MODE_PROG_IE]);

   // APB answer: zero wait, error on unmapped
   assign pready  = access_ph;
   assign pslverr = access_ph & ~mapped;
   assign prdata  = prdata_q;

   // Flash read wait states
   wire [1:0] ws = mode_q[`MODE_WS_LSB +: 2];
   assign fr_ready = fr_req & (ws_cnt_q == ws);

   // Controller sequencing
   always_comb begin
      state_d = state_q;
      case (state_q)
         CTRL_IDLE: begin
            if (cmd_go) begin
               state_d = CTRL_BUSY;
            end else if (pin_go) begin
               state_d = CTRL_PIN_ERASE;
            end
         end
         CTRL_BUSY: begin
            if (nvm_done) begin
               state_d = CTRL_IDLE;
            end
         end
         CTRL_PIN_ERASE: begin
            if (nvm_done) begin
               state_d = CTRL_IDLE;
            end
         end
         default: state_d = CTRL_IDLE;
      endcase
   end

   // Read data captured in the setup phase
   wire [31:0] status_word = {8'h00, lock_q, 6'h00, gpnv_q, 3'h0, sec_q,
                              prog_err_q, lock_err_q, 1'b0, idle};
   wire [31:0] rd_mux = hit_mode  ? mode_q :
                        hit_stat  ? status_word :
                        hit_remap ? {31'h0, remap_q} : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup_ph) begin
         prdata_q <= rd_mux;
      end
   end

   // Mode register and remap flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q  <= `MODE_RESET;
         remap_q <= 1'b0;
      end else begin
         if (wr_en & hit_mode) begin
            mode_q <= {22'h0, pwdata[9:8], 6'h0, pwdata[1:0]};
         end
         if (wr_en & hit_remap & pwdata[0]) begin
            remap_q <= 1'b1;
         end
      end
   end

   // Error flags: set wins over read-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_err_q <= 1'b0;
         prog_err_q <= 1'b0;
      end else begin
         lock_err_q <= cmd_lock | (lock_err_q & ~rd_stat);
         prog_err_q <= cmd_bad | (prog_err_q & ~rd_stat);
      end
   end

   // Erase pin synchroniser and hold counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         erase_s1_q <= 1'b0;
         erase_s2_q <= 1'b0;
         hold_cnt_q <= 32'h0000_0000;
      end else begin
         erase_s1_q <= erase_pin;
         erase_s2_q <= erase_s1_q;
         if (!pin_high) begin
            hold_cnt_q <= 32'h0000_0000;
         end else if (!held_long) begin
            hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
         end
      end
   end

   // Operation launch towards the flash array
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q  <= CTRL_IDLE;
         start_q  <= 1'b0;
         op_q     <= 8'h00;
         page_q   <= 8'h00;
      end else begin
         state_q <= state_d;
         start_q <= cmd_go | pin_go;
         if (cmd_go) begin
            op_q   <= code;
            page_q <= page;
         end else if (pin_go) begin
            op_q   <= `CMD_ERASE_ALL;
            page_q <= 8'h00;
         end
      end
   end

   // Non-volatile bits: loaded from the image, then changed on completion or while the erase pin is high
   wire done_cmd = (state_q == CTRL_BUSY) & nvm_done;
   wire done_pin = (state_q == CTRL_PIN_ERASE) & nvm_done;
   wire [2:0] op_region = page_q[7:5];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_q        <= 1'b1;
         lock_q        <= 8'h00;
         gpnv_q        <= 2'b00;
         sec_q         <= 1'b0;
         erase_armed_q <= 1'b0;
      end else if (load_q) begin
         load_q <= 1'b0;
         lock_q <= nv_lock_image;
         gpnv_q <= nv_gpnv_image;
         sec_q  <= nv_sec_image;
      end else begin
         // Arm once per assertion, so a held pin erases only once
         if (done_pin) begin
            sec_q         <= 1'b0;
            erase_armed_q <= 1'b0;
         end else if (pin_high && hold_cnt_q == 32'h0000_0000) begin
            erase_armed_q <= 1'b1;
         end
         if (pin_high) begin
            lock_q <= 8'h00;
            gpnv_q <= 2'b00;
         end else if (done_cmd) begin
            case (op_q)
               `CMD_SET_LOCK: lock_q[op_region] <= 1'b1;
               `CMD_CLR_LOCK: lock_q[op_region] <= 1'b0;
               `CMD_SET_GPNV: gpnv_q[page_q[0]] <= 1'b1;
               `CMD_CLR_GPNV: gpnv_q[page_q[0]] <= 1'b0;
               `CMD_SET_SEC:  sec_q <= 1'b1;
               default: ;
            endcase
         end
      end
   end

   // Wait-state counter for flash reads
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ws_cnt_q <= 2'b00;
      end else if (!fr_req || fr_ready) begin
         ws_cnt_q <= 2'b00;
      end else begin
         ws_cnt_q <= ws_cnt_q + 2'b01;
      end
   end

   // Checks
   property p_lock_abort;
      @(posedge pclk) disable iff (!presetn)
      cmd_lock |=> lock_err_q && !start_q && $stable(lock_q);
   endproperty
   a_lock_abort: assert property (p_lock_abort) else $error("lock abort");

   property p_irq_lock;
      @(posedge pclk) disable iff (!presetn)
      (lock_err_q && !mode_q[`MODE_LOCK_IE] && !prog_err_q) |-> !flash_irq;
   endproperty
   a_irq_lock: assert property (p_irq_lock) else $error("lock irq");

   property p_badkey;
      @(posedge pclk) disable iff (!presetn)
      (cmd_wr && !key_ok) |=> prog_err_q && !start_q;
   endproperty
   a_badkey: assert property (p_badkey) else $error("key check");

   property p_pin_clear;
      @(posedge pclk) disable iff (!presetn)
      (pin_high && !load_q) |=> lock_q == 8'h00 && gpnv_q == 2'b00;
   endproperty
   a_pin_clear: assert property (p_pin_clear) else $error("pin clear");

   property p_sec_gate;
      @(posedge pclk) disable iff (!presetn)
      sec_q |-> !ice_flash_grant && !fast_flash_program_port_flash_grant;
   endproperty
   a_sec_gate: assert property (p_sec_gate) else $error("sec gate");

   property p_sec_fall;
      @(posedge pclk) disable iff (!presetn)
      $fell(sec_q) |-> $past(done_pin) || $past(load_q);
   endproperty
   a_sec_fall: assert property (p_sec_fall) else $error("sec clear");

   property p_remap;
      @(posedge pclk) disable iff (!presetn)
      (at_zero && !remap_q) |-> sel_flash && !sel_sram && !sel_rom;
   endproperty
   a_remap: assert property (p_remap) else $error("boot map");

   property p_ws;
      @(posedge pclk) disable iff (!presetn)
      ($rose(fr_req) && ws == 2'd3) |-> !fr_ready [*3] ##1 fr_ready;
   endproperty
   a_ws: assert property (p_ws) else $error("wait states");

   c_lock_err: cover property (@(posedge pclk) disable iff (!presetn)
      cmd_lock);
   c_pin_erase: cover property (@(posedge pclk) disable iff (!presetn)
      done_pin);
   c_remap: cover property (@(posedge pclk) disable iff (!presetn)
      $rose(remap_q));
endmodule

`default_nettype wire

// >>> flash_lock_security_remap_tb.sv
// Self-checking bench for the lock, security and remap block.
// Assumes the design, its package and the flash array model.
`timescale 1ns/1ps
`default_nettype none

module flash_lock_security_remap_tb;
   import flash_lock_pkg::*;
   localparam logic [7:0] KEY = 8'h3C; // Arbitrary key
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, cpu_addr, rd;
   logic sel_sram, sel_flash, sel_rom, fr_req, fr_ready, se;
   logic ice_req, ice_gnt, fast_flash_program_port_req, fast_flash_program_port_gnt, erase_pin, slow;
   logic nvm_start, nvm_done, security, bod_en, bod_rst, irq;
   logic [7:0] nvm_op, nvm_page, nv_lock;
   logic [7:0] last_op = 8'h00;
   logic [1:0] nv_gpnv;
   logic nv_sec;
   lock_vec_type lock_bits;
   int err_total, samples_checked, n;
   int starts = 0;

   flash_lock_security_remap #(.CMD_KEY(KEY), .ERASE_HOLD_CYCLES(8)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cpu_addr(cpu_addr),
      .sel_sram(sel_sram), .sel_flash(sel_flash), .sel_rom(sel_rom),
      .fr_req(fr_req), .fr_ready(fr_ready), .ice_flash_req(ice_req),
      .ice_flash_grant(ice_gnt), .fast_flash_program_port_flash_req(fast_flash_program_port_req),
      .fast_flash_program_port_flash_grant(fast_flash_program_port_gnt), .erase_pin(erase_pin),
      .nv_lock_image(nv_lock), .nv_gpnv_image(nv_gpnv),
      .nv_sec_image(nv_sec),
      .nvm_start(nvm_start), .nvm_op(nvm_op), .nvm_page(nvm_page),
      .nvm_done(nvm_done), .lock_bits(lock_bits), .security(security),
      .bod_enable(bod_en), .bod_reset_enable(bod_rst), .flash_irq(irq));

   flash_array_model array (.pclk(pclk), .presetn(presetn), .slow(slow),
      .nvm_start(nvm_start), .nvm_done(nvm_done));

   // Clock and a tally of started operations
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (nvm_start === 1'b1) begin
         starts  <= starts + 1;
         last_op <= nvm_op;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("mismatches %0d, checks %0d", err_total, samples_checked);
      if (err_total == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic fail();
      err_total++;
      $display("unexpected at %0t: wait ran out", $time);
      wrap_up();
   endtask

   // One APB transfer; read data and error taken at the ready edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) fail();
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic cmd(input logic [7:0] code, input logic [7:0] page,
                      input logic [7:0] key);
      apb(1'b1, 12'h004, {key, 8'h00, page, code});
   endtask

   // Poll the status register until the controller reports idle
   task automatic run(input logic [7:0] code, input logic [7:0] page);
      int k;
      cmd(code, page, KEY);
      for (k = 0; k < 40; k++) begin
         apb(1'b0, 12'h008, 32'h0000_0000);
         if (rd[0] === 1'b1) break;
      end
      if (k == 40) fail();
   endtask

   task automatic dec(input logic [31:0] a, input logic [2:0] exp);
      @(posedge pclk);
      cpu_addr <= a;
      @(negedge pclk);
      chk({sel_sram, sel_flash, sel_rom}, exp);
   endtask

   task automatic t_map();
      dec(32'h0000_0000, 3'b010);
      dec(32'h0010_0000, 3'b010);
      dec(32'h0020_0000, 3'b100);
      apb(1'b1, 12'h00C, 32'h0000_0001);
      dec(32'h0000_0000, 3'b100);
      dec(32'h0020_0004, 3'b100);
      dec(32'h0010_0000, 3'b010);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk({31'h0, se}, 32'h0000_0001); // Unmapped answers with error
      chk(rd, 32'h0000_0000);
   endtask

   task automatic t_lock();
      int s0;
      cmd(8'h02, 8'h20, 8'h00);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk({rd[3], lock_bits}, {1'b1, 8'h00});
      run(8'h02, 8'h40);
      chk(lock_bits, 8'h04);
      s0 = starts;
      cmd(8'h01, 8'h5F, KEY);
      repeat (3) @(posedge pclk);
      chk(irq, 1'b0);
      apb(1'b1, 12'h000, 32'h0000_0003);
      @(negedge pclk);
      chk({irq, lock_bits}, {1'b1, 8'h04});
      chk(starts, s0);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd[2], 1'b1);
      run(8'h04, 8'h40);
      chk({irq, lock_bits}, {1'b0, 8'h00});
      run(8'h02, 8'hE0);
      chk({lock_bits, nvm_page}, {8'h80, 8'hE0});
      // Erase-all with a region locked, then an unknown code
      s0 = starts;
      cmd(8'h08, 8'h00, KEY);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk({rd[3:2], lock_bits}, {2'b01, 8'h80});
      cmd(8'h33, 8'h00, KEY);
      @(negedge pclk);
      chk(irq, 1'b1);
      chk(starts, s0);
      run(8'h01, 8'h00);
      chk(last_op, 8'h01);
   endtask

   task automatic t_gpnv();
      slow <= 1'b1;
      run(8'h0B, 8'h00);
      chk({bod_en, bod_rst}, 2'b10);
      run(8'h0B, 8'h01);
      chk({bod_en, bod_rst}, 2'b11);
      run(8'h0D, 8'h00);
      chk({bod_en, bod_rst}, 2'b01);
      run(8'h0B, 8'h00);
      slow <= 1'b0;
   endtask

   task automatic t_sec();
      ice_req <= 1'b1;
      fast_flash_program_port_req <= 1'b1;
      run(8'h0F, 8'h00);
      run(8'h0D, 8'h01);
      @(negedge pclk);
      chk({security, ice_gnt, fast_flash_program_port_gnt}, 3'b100);
      @(posedge pclk);
      erase_pin <= 1'b1; // Held well past the hold count
      repeat (4) @(posedge pclk);
      chk({lock_bits, bod_en, bod_rst}, 10'h000);
      chk(security, 1'b1);
      for (n = 0; n < 60 && security !== 1'b0; n++) @(posedge pclk);
      if (n == 60) fail();
      chk({last_op, nvm_page}, {8'h08, 8'h00});
      erase_pin <= 1'b0;
      @(negedge pclk);
      chk({ice_gnt, fast_flash_program_port_gnt}, 2'b11);
   endtask

   // Wait states 0 and 3 on flash reads
   task automatic t_wait();
      int ws;
      for (ws = 0; ws < 4; ws += 3) begin
         apb(1'b1, 12'h000, {22'h0, ws[1:0], 8'h00});
         @(posedge pclk);
         fr_req <= 1'b1;
         for (n = 0; n < 8; n++) begin
            @(negedge pclk);
            if (fr_ready === 1'b1) break;
         end
         chk(n, ws);
         @(posedge pclk);
         fr_req <= 1'b0;
      end
   endtask

   // Reset in mid-run: remap drops, state reloads from the stored image
   task automatic t_reset();
      nv_lock <= 8'h5A;
      nv_gpnv <= 2'b10;
      nv_sec <= 1'b1;
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk({lock_bits, bod_en, bod_rst, security, ice_gnt, fast_flash_program_port_gnt},
          {8'h5A, 2'b01, 3'b100});
      dec(32'h0000_0000, 3'b010);
   endtask

   initial begin
      {psel, penable, pwrite, fr_req, ice_req, fast_flash_program_port_req} = 6'b0;
      {erase_pin, slow} = 2'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      cpu_addr = 32'h0000_0000;
      err_total = 0;
      samples_checked = 0;
      {nv_lock, nv_gpnv, nv_sec} = 11'h000;
      presetn = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_map();
      t_lock();
      t_gpnv();
      t_sec();
      t_wait();
      t_reset();
      wrap_up();
   end
endmodule
`default_nettype wire
